/* design/quad_sgmii_pcs_lane_mux.sv */
// Purpose: four PCS ports joined onto one 32-bit transceiver stream and split again
// Assumes: all client and transceiver signals run on ref_clk (fabric octet clock)
// Notes: management is reached over the plain register port
// Overview of operation
// - transmit engine turns GMII into ordered sets
// - idle is always first idle variant
// - receive synchronisation runs before decoding
// - receive engine rebuilds GMII octets, valid, error
// - disparity checking per port, off after reset
// - four lanes form 32-bit data, 4-bit control
// - port 0 transmit commas become port marker
// - search every received lane for marker
// - marker lane is port 0, next lanes follow
// - port 0 receive marker turned back to comma
// - each port has 128-entry elastic buffer
// - buffer adds/drops idle variant by disparity mode
// - per-port speed 10, 100 or 1000
// - frame length bounded by nothing inside
// - full duplex only
// - management registers reachable per port
// - configuration vector loads control and advertisement
// - negotiation seen only through management registers
// - MAC-side or PHY-side mode
// - all GMII signals on the octet clock
// - port 0 transmit latency five cycles
// - port 0 receive latency six cycles
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module quad_sgmii_pcs_lane_mux #(
	parameter int EB_DEPTH = 128
) (
	input  wire logic                          ref_clk,
	input  wire logic                          reset,
	input  wire logic                          clk_en,
	input  wire logic [31:0]                   gmii_txd,
	input  wire logic [3:0]                    gmii_tx_en,
	input  wire logic [3:0]                    gmii_tx_er,
	output logic      [31:0]                   gmii_rxd,
	output logic      [3:0]                    gmii_rx_dv,
	output logic      [3:0]                    gmii_rx_er,
	output logic      [3:0]                    gmii_isolate,
	output logic      [31:0]                   txdata,
	output logic      [3:0]                    txcharisk,
	input  wire logic [31:0]                   rxdata,
	input  wire logic [3:0]                    rxcharisk,
	input  wire logic [3:0]                    rxdisperr,
	input  wire logic [3:0]                    rxnotintable,
	input  wire logic                          cfg_load,
	input  wire logic [1:0]                    cfg_port,
	input  wire logic [15:0]                   cfg_ctrl,
	input  wire logic [15:0]                   cfg_adv,
	input  wire logic [qsgmii_pkg::REG_AW-1:0] reg_addr,
	input  wire logic [31:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [31:0]                   reg_rdata
);
	import qsgmii_pkg::*;

	localparam int PW = $clog2(EB_DEPTH);
	localparam logic [PW:0] EB_HI = (PW+1)'(EB_DEPTH * 3 / 4);
	localparam logic [PW:0] EB_LO = (PW+1)'(EB_DEPTH / 4);

	logic [15:0] ctrl [4];
	logic [15:0] adv [4];
	logic        phy_mode;
	logic        aligned;
	logic [1:0]  lane_ofs;
	logic [31:0] agg_d;
	logic [3:0]  agg_k;
	logic [31:0] p4_d;
	logic [3:0]  p4_k;
	wire logic [31:0] enc_d;
	wire logic [3:0]  enc_k;
	wire logic [3:0]  hit;
	wire logic [3:0]  sync_ok;
	wire logic [3:0]  sync_drop;
	logic [1:0]  first_hit;

	// register port decode
	wire logic       word_ok  = reg_addr[1:0] == 2'h0;
	wire logic [1:0] idx      = reg_addr[3:2];
	wire logic       sel_ctrl = word_ok && reg_addr[7:4] == OFS_CTRL[7:4];
	wire logic       sel_adv  = word_ok && reg_addr[7:4] == OFS_ADV[7:4];
	wire logic       sel_stat = reg_addr == OFS_STAT;
	wire logic       sel_mode = reg_addr == OFS_MODE;
	wire logic [31:0] rd_mux =
		sel_ctrl ? {16'h0000, ctrl[idx]} :
		sel_adv  ? {16'h0000, adv[idx]} :
		sel_stat ? {25'h0, lane_ofs, aligned, sync_ok} :
		sel_mode ? {31'h0, phy_mode} : 32'h0;

	// management access per port, incl. negotiation words
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				ctrl[i] <= CTRL_RESET; // disparity check off
				adv[i] <= ADV_RESET;
			end
			phy_mode <= 1'b0;
			reg_rdata <= 32'h0;
		end else if (clk_en) begin
			if (reg_wr && sel_ctrl)
				ctrl[idx] <= reg_wdata[15:0];
			if (reg_wr && sel_adv)
				adv[idx] <= reg_wdata[15:0];
			if (reg_wr && sel_mode)
				phy_mode <= reg_wdata[MODE_PHY_BIT];
			if (cfg_load) begin
				ctrl[cfg_port] <= cfg_ctrl; // vector wins over bus
				adv[cfg_port] <= cfg_adv;
			end
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
		end
	end

	// isolate only matters with an external GMII
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			gmii_isolate <= 4'h0;
		else if (clk_en)
			for (int i = 0; i < 4; i++)
				gmii_isolate[i] <= phy_mode & ctrl[i][CTRL_ISO_BIT];
	end

	// aggregator with port 0 comma swap, three stages to the pins
	wire logic [7:0] lane0 = (enc_k[0] && enc_d[7:0] == K28_5) ? K28_1 : enc_d[7:0];
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			agg_d <= 32'h0;
			agg_k <= 4'h0;
			p4_d <= 32'h0;
			p4_k <= 4'h0;
			txdata <= 32'h0;
			txcharisk <= 4'h0;
		end else if (clk_en) begin
			agg_d <= {enc_d[31:8], lane0};
			agg_k <= enc_k;
			p4_d <= agg_d;
			p4_k <= agg_k;
			txdata <= p4_d;
			txcharisk <= p4_k;
		end
	end

	// lowest lane carrying the marker
	always_comb begin
		first_hit = 2'h0;
		for (int i = 3; i >= 0; i--)
			if (hit[i])
				first_hit = 2'(i);
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			aligned <= 1'b0;
			lane_ofs <= 2'h0;
		end else if (clk_en) begin
			if (!aligned && |hit) begin
				aligned <= 1'b1;
				lane_ofs <= first_hit;
			end else if (aligned && sync_drop[0])
				aligned <= 1'b0;
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_port
		logic [7:0]  t_d;
		logic        t_en;
		logic        t_er;
		tx_e         st;
		tx_e         next_st;
		logic [7:0]  e_d;
		logic        e_k;
		logic [7:0]  next_d;
		logic        next_k;
		logic        ev;
		logic [7:0]  a_d;
		logic        a_k;
		logic        a_b;
		logic [9:0]  mem [EB_DEPTH];
		logic [PW:0] wp;
		logic [PW:0] rp;
		logic        lw_com;
		logic        run;
		logic [7:0]  q_d;
		logic        q_k;
		logic        q_b;
		logic        q_v;
		sync_e       sy;
		logic [1:0]  cnt;
		logic [1:0]  good;
		rx_e         rs;
		rx_e         next_rs;
		logic [7:0]  nd;
		logic        nv;
		logic        ne;
		logic [9:0]  dec;
		logic [9:0]  dp [4];
		logic [6:0]  rc;
		logic [9:0]  o;

		wire logic [1:0] spd = ctrl[g][CTRL_SPD_LSB+:2];
		wire logic       disp_en = ctrl[g][CTRL_DISP_BIT];
		wire logic [1:0] ln = 2'(lane_ofs + 2'(g));
		wire logic [7:0] rot_d = rxdata[8*ln+:8];
		wire logic       rot_k = rxcharisk[ln];
		wire logic       rot_b = rxnotintable[ln] | (rxdisperr[ln] & disp_en);
		wire logic [7:0] cc = disp_en ? D16_2 : D5_6;
		wire logic [PW:0] fill = wp - rp;
		wire logic       del = fill > EB_HI && lw_com && !a_k && a_d == cc;
		wire logic [9:0] rd_w = mem[rp[PW-1:0]];
		wire logic       ins = fill < EB_LO && q_v && q_k && q_d == K28_5
			&& !rd_w[8] && rd_w[7:0] == cc;
		wire logic       comma = q_v && q_k && q_d == K28_5;
		wire logic       bad = q_v && q_b;
		wire logic       smp = rc == 7'h0;

		assign hit[g] = rxcharisk[g] && rxdata[8*g+:8] == K28_1;
		assign enc_d[8*g+:8] = e_d;
		assign enc_k[g] = e_k;
		assign sync_ok[g] = sy == SY_OK;
		assign sync_drop[g] = sy == SY_OK && bad && cnt == SYNC_BAD_MAX;
		assign {gmii_rx_er[g], gmii_rx_dv[g], gmii_rxd[8*g+:8]} = o;

		// transmit encoder: start, data, end, carrier, first idle only
		always_comb begin
			next_st = st;
			next_k = 1'b1;
			next_d = ev ? K28_5 : D5_6;
			unique case (st)
				TX_IDLE: if (t_en && ev) begin
					next_d = K_SOP;
					next_st = TX_DATA;
				end else begin
					next_k = ev; // odd idle half is a data group
				end
				TX_DATA: if (t_en) begin
					next_k = t_er;
					next_d = t_er ? K_ERR : t_d;
				end else begin
					next_d = K_EOP;
					next_st = TX_END;
				end
				TX_END: begin
					next_d = K_CAR;
					next_st = ev ? TX_CAR : TX_IDLE; // idle restarts even
				end
				TX_CAR: begin
					next_d = K_CAR;
					next_st = TX_IDLE;
				end
			endcase
		end

		// client inputs sampled on the octet clock; slow speeds hold bytes
		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				{t_d, t_en, t_er} <= 10'h0;
				st <= TX_IDLE;
				e_d <= K28_5;
				e_k <= 1'b1;
				ev <= 1'b1;
			end else if (clk_en) begin
				t_d <= gmii_txd[8*g+:8];
				t_en <= gmii_tx_en[g];
				t_er <= gmii_tx_er[g];
				st <= next_st;
				e_d <= next_d;
				e_k <= next_k;
				ev <= !ev;
			end
		end

		// elastic buffer; no length counter, frames of any size pass
		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				{a_d, a_k, a_b} <= 10'h0;
				wp <= '0;
				rp <= '0;
				lw_com <= 1'b0;
				run <= 1'b0;
				{q_d, q_k, q_b, q_v} <= 11'h0;
			end else if (clk_en) begin
				a_d <= (g == 0 && rot_k && rot_d == K28_1) ? K28_5 : rot_d;
				a_k <= rot_k;
				a_b <= rot_b;
				if (aligned) begin
					if (!del)
						mem[wp[PW-1:0]] <= {a_b, a_k, a_d};
					wp <= del ? wp - 1'b1 : wp + 1'b1; // drop idle pair
					lw_com <= a_k && a_d == K28_5;
				end
				if (!aligned)
					run <= 1'b0;
				else if (fill >= EB_LO)
					run <= 1'b1;
				q_v <= run && fill != '0;
				if (run && fill != '0) begin
					{q_b, q_k, q_d} <= rd_w;
					rp <= ins ? rp - 1'b1 : rp + 1'b1; // repeat idle pair
				end
			end
		end

		// code-group synchronisation
		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				sy <= SY_LOSS;
				cnt <= 2'h0;
				good <= 2'h0;
			end else if (clk_en) begin
				if (!aligned) begin
					sy <= SY_LOSS;
					cnt <= 2'h0;
				end else unique case (sy)
					SY_LOSS: if (comma) begin
						sy <= SY_ACQ;
						cnt <= 2'h1;
					end
					SY_ACQ: if (bad) begin
						sy <= SY_LOSS;
					end else if (comma) begin
						cnt <= cnt == SYNC_COMMA_MAX ? 2'h0 : cnt + 1'b1;
						if (cnt == SYNC_COMMA_MAX)
							sy <= SY_OK;
					end
					SY_OK: if (bad) begin
						good <= 2'h0;
						if (cnt == SYNC_BAD_MAX)
							sy <= SY_LOSS;
						else
							cnt <= cnt + 1'b1;
					end else if (cnt != 2'h0) begin
						good <= good + 1'b1;
						if (good == SYNC_GOOD_MAX)
							cnt <= cnt - 1'b1;
					end
				endcase
			end
		end

		// receive decoder; silent until aligned and in sync
		always_comb begin
			next_rs = rs;
			nd = 8'h00;
			nv = 1'b0;
			ne = 1'b0;
			if (!aligned || sy != SY_OK || !q_v)
				next_rs = RX_IDLE;
			else unique case (rs)
				RX_IDLE: if (q_k && q_d == K_SOP) begin
					nv = 1'b1;
					nd = PREAMBLE;
					next_rs = RX_DATA;
				end
				RX_DATA: if (!q_k) begin
					nv = 1'b1;
					nd = q_d;
					ne = q_b;
				end else if (q_d == K_ERR) begin
					nv = 1'b1;
					ne = 1'b1;
				end else begin
					nv = q_d != K_EOP; // early end flagged
					ne = q_d != K_EOP;
					next_rs = RX_IDLE;
				end
			endcase
		end

		// full duplex only: no carrier sense or collision
		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				rs <= RX_IDLE;
				dec <= 10'h0;
				for (int i = 0; i < 4; i++)
					dp[i] <= 10'h0;
				rc <= 7'h0;
				o <= 10'h0;
			end else if (clk_en) begin
				rs <= next_rs;
				dec <= {ne, nv, nd};
				dp[0] <= dec;
				for (int i = 1; i < 4; i++)
					dp[i] <= dp[i-1];
				rc <= smp ? (spd == SPD_10 ? REP_10 - 1'b1 :
					spd == SPD_100 ? REP_100 - 1'b1 : 7'h0) : rc - 1'b1;
				if (!aligned)
					o <= 10'h0; // drop a held slow-speed octet at once
				else if (smp)
					o <= dp[3];
			end
		end
	end

	property p_tx_latency;
		@(posedge ref_clk) disable iff (reset)
		(g_port[0].st == TX_DATA && g_port[0].t_en && !g_port[0].t_er)
			##0 clk_en[*5] |-> txdata[7:0] == $past(g_port[0].t_d, 4);
	endproperty
	a_tx_latency: assert property (p_tx_latency) else $error("port 0 tx latency wrong");

	property p_tx_swap;
		@(posedge ref_clk) disable iff (reset)
		txcharisk[0] |-> txdata[7:0] != K28_5;
	endproperty
	a_tx_swap: assert property (p_tx_swap) else $error("comma left on port 0 lane");

	property p_idle_i1;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && g_port[1].st == TX_IDLE && !g_port[1].t_en)
			|=> g_port[1].e_d == (g_port[1].e_k ? K28_5 : D5_6);
	endproperty
	a_idle_i1: assert property (p_idle_i1) else $error("second idle variant sent");

	property p_rx_swap;
		@(posedge ref_clk) disable iff (reset)
		g_port[0].a_k |-> g_port[0].a_d != K28_1;
	endproperty
	a_rx_swap: assert property (p_rx_swap) else $error("marker reached port 0");

	sequence s_unaligned;
		(!aligned && clk_en)[*7];
	endsequence
	property p_align_gate;
		@(posedge ref_clk) disable iff (reset)
		s_unaligned |-> gmii_rx_dv == 4'h0;
	endproperty
	a_align_gate: assert property (p_align_gate) else $error("rx data before align");

	// one-hot of the chosen lane: it carried the marker and no lower lane did
	wire logic [3:0] ofs_bit = 4'h1 << lane_ofs;
	property p_align_lane;
		@(posedge ref_clk) disable iff (reset)
		$rose(aligned) |-> ($past(hit) & ofs_bit) != 4'h0
			&& ($past(hit) & (ofs_bit - 4'h1)) == 4'h0;
	endproperty
	a_align_lane: assert property (p_align_lane) else $error("port 0 lane not marker");

	property p_eb_bound;
		@(posedge ref_clk) disable iff (reset)
		g_port[0].fill <= (PW+1)'(EB_DEPTH);
	endproperty
	a_eb_bound: assert property (p_eb_bound) else $error("elastic buffer overrun");

	property p_rx_latency;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && aligned && ctrl[0][CTRL_SPD_LSB+:2] == 2'h2)[*6]
			|-> {gmii_rx_er[0], gmii_rx_dv[0], gmii_rxd[7:0]} == $past(g_port[0].dec, 5);
	endproperty
	a_rx_latency: assert property (p_rx_latency) else $error("port 0 rx latency wrong");

	property p_cfg_load;
		@(posedge ref_clk) disable iff (reset)
		(clk_en && cfg_load && cfg_port == 2'h3)
			|=> ctrl[3] == $past(cfg_ctrl) && adv[3] == $past(cfg_adv);
	endproperty
	a_cfg_load: assert property (p_cfg_load) else $error("config vector not taken");
endmodule : quad_sgmii_pcs_lane_mux
`default_nettype wire

/* design/qsgmii_pkg.sv */
// Purpose: shared constants and types for the quad PCS lane mux
// Assumes: a code group is a byte plus a control flag
// Notes: register offsets are byte addresses of 32-bit words
package qsgmii_pkg;
	localparam int REG_AW = 8;
	localparam logic [7:0] K28_5 = 8'hBC;
	localparam logic [7:0] K28_1 = 8'h3C;
	localparam logic [7:0] D5_6 = 8'hC5;
	localparam logic [7:0] D16_2 = 8'h50;
	localparam logic [7:0] K_SOP = 8'hFB;
	localparam logic [7:0] K_EOP = 8'hFD;
	localparam logic [7:0] K_CAR = 8'hF7;
	localparam logic [7:0] K_ERR = 8'hFE;
	localparam logic [7:0] PREAMBLE = 8'h55;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADV = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h20;
	localparam logic [7:0] OFS_MODE = 8'h24;
	localparam int CTRL_SPD_LSB = 0;
	localparam int CTRL_DISP_BIT = 2;
	localparam int CTRL_ISO_BIT = 3;
	localparam int MODE_PHY_BIT = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0002;
	localparam logic [15:0] ADV_RESET = 16'h0001;
	localparam logic [1:0] SPD_10 = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [6:0] REP_10 = 7'h64;
	localparam logic [6:0] REP_100 = 7'h0A;
	localparam int TX_LAT = 5;
	localparam int RX_LAT = 6;
	localparam logic [1:0] SYNC_COMMA_MAX = 2'h2;
	localparam logic [1:0] SYNC_BAD_MAX = 2'h3;
	localparam logic [1:0] SYNC_GOOD_MAX = 2'h3;
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_DATA = 4'b0010,
		TX_END  = 4'b0100,
		TX_CAR  = 4'b1000
	} tx_e;
	typedef enum logic [2:0] {
		SY_LOSS = 3'b001,
		SY_ACQ  = 3'b010,
		SY_OK   = 3'b100
	} sync_e;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_DATA = 2'b10
	} rx_e;
endpackage : qsgmii_pkg

/* testbench/qsgmii_peer_model.sv */
// Purpose: far-end peer that loops our lanes back with a lane rotation
// Assumes: the transceiver shares ref_clk with the block
// Notes: before link_up the lines carry changing junk, never a stale idle
`timescale 1ns/1ns
`default_nettype none
module qsgmii_peer_model (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [31:0] txdata,
	input  wire logic [3:0]  txcharisk,
	input  wire logic        link_up,
	input  wire logic [1:0]  rot,
	input  wire logic [3:0]  disp_bad,
	output logic      [31:0] rxdata,
	output logic      [3:0]  rxcharisk,
	output logic      [3:0]  rxdisperr,
	output logic      [3:0]  rxnotintable
);
	logic [7:0] junk;
	// our lane i arrives on lane i+rot, so port 0 may land anywhere
	function automatic logic [1:0] dest(input int i, input logic [1:0] r);
		return 2'(i) + r;
	endfunction : dest
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			junk <= 8'h00;
			rxdata <= 32'h0;
			rxcharisk <= 4'h0;
			rxdisperr <= 4'h0;
			rxnotintable <= 4'hF;
		end else begin
			junk <= junk + 8'h1D;
			for (int i = 0; i < 4; i++) begin
				rxdata[8*dest(i, rot) +: 8] <= link_up ? txdata[8*i +: 8] : junk ^ 8'(i);
				rxcharisk[dest(i, rot)] <= link_up & txcharisk[i];
				rxdisperr[dest(i, rot)] <= link_up & disp_bad[i];
				rxnotintable[dest(i, rot)] <= ~link_up;
			end
		end
	end
endmodule : qsgmii_peer_model
`default_nettype wire

/* testbench/quad_sgmii_pcs_lane_mux_tb.sv */
// Purpose: self-checking bench for the quad PCS lane mux
// Assumes: peer model loops transmit lanes back rotated by two lanes
// Notes: elastic buffer shortened to 8 entries for run time
`timescale 1ns/1ns
`default_nettype none
module quad_sgmii_pcs_lane_mux_tb;
	import qsgmii_pkg::*;
	logic              ref_clk, reset, clk_en, cfg_load, reg_wr, reg_rd, link_up;
	logic       [31:0] gmii_txd, gmii_rxd, txdata, rxdata, reg_wdata, reg_rdata, rd, tx_hold;
	logic       [3:0]  gmii_tx_en, gmii_tx_er, gmii_rx_dv, gmii_rx_er, gmii_isolate;
	logic       [3:0]  txcharisk, rxcharisk, rxdisperr, rxnotintable, disp_bad;
	logic       [1:0]  cfg_port;
	logic       [15:0] cfg_ctrl, cfg_adv;
	logic       [7:0]  reg_addr;
	int                fail_count, tests_run, lat;

	quad_sgmii_pcs_lane_mux #(.EB_DEPTH(8)) uut (.ref_clk(ref_clk), .reset(reset),
		.clk_en(clk_en), .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en),
		.gmii_tx_er(gmii_tx_er), .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv),
		.gmii_rx_er(gmii_rx_er), .gmii_isolate(gmii_isolate), .txdata(txdata),
		.txcharisk(txcharisk), .rxdata(rxdata), .rxcharisk(rxcharisk),
		.rxdisperr(rxdisperr), .rxnotintable(rxnotintable), .cfg_load(cfg_load),
		.cfg_port(cfg_port), .cfg_ctrl(cfg_ctrl), .cfg_adv(cfg_adv),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	qsgmii_peer_model peer (.ref_clk(ref_clk), .reset(reset), .txdata(txdata),
		.txcharisk(txcharisk), .link_up(link_up), .rot(2'h2), .disp_bad(disp_bad),
		.rxdata(rxdata), .rxcharisk(rxcharisk), .rxdisperr(rxdisperr),
		.rxnotintable(rxnotintable));

	always #10 ref_clk = ~ref_clk;

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_read

	function automatic logic [7:0] frame_byte(input int p, input int i);
		case (i)
			0, 1: return PREAMBLE;
			2: return 8'hD5;
			3: return 8'(16 * p + 1);
			4: return 8'(16 * p + 2);
			default: return 8'h30;
		endcase
	endfunction : frame_byte

	task automatic send_frame(input int p);
		// a comma on the pins puts our first byte on an even code group
		do begin
			@(posedge ref_clk);
			#1;
		end while (txcharisk[p] !== 1'b1);
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			gmii_tx_en[p] <= 1'b1;
			gmii_tx_er[p] <= (p == 1 && i == 4);
			gmii_txd[8*p +: 8] <= frame_byte(p, i);
		end
		@(posedge ref_clk);
		gmii_tx_en[p] <= 1'b0;
		gmii_tx_er[p] <= 1'b0;
	endtask : send_frame

	task automatic recv_frame(input int p);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (gmii_rx_dv[p] !== 1'b1 && n < 400);
		for (int i = 0; i < 6; i++) begin
			if (p == 1 && i == 4)
				check_val(32'({gmii_rx_dv[p], gmii_rx_er[p]}), 32'h3);
			else
				check_val(32'({gmii_rx_dv[p], gmii_rx_er[p], gmii_rxd[8*p +: 8]}),
					32'({2'b10, frame_byte(p, i)}));
			@(posedge ref_clk);
			#1;
		end
		check_val(32'(gmii_rx_dv[p]), 32'h0);
	endtask : recv_frame

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	initial begin
		#(20 * 30000);
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end

	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		clk_en = 1'b1;
		{cfg_load, reg_wr, reg_rd, link_up} = 4'h0;
		{gmii_txd, gmii_tx_en, gmii_tx_er, disp_bad} = 44'h0;
		{cfg_port, cfg_ctrl, cfg_adv, reg_addr, reg_wdata} = 74'h0;
		fail_count = 0;
		tests_run = 0;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;

		reg_read(OFS_CTRL, rd);
		check_val(rd, 32'h0002);
		reg_read(OFS_ADV, rd);
		check_val(rd, 32'h0001);
		reg_read(OFS_MODE, rd);
		check_val(rd, 32'h0);
		reg_read(8'h30, rd);
		check_val(rd, 32'h0);
		reg_write(OFS_CTRL + 8'h04, 32'h0001);
		reg_read(OFS_CTRL + 8'h04, rd);
		check_val(rd, 32'h0001);
		reg_read(OFS_CTRL, rd);
		check_val(rd, 32'h0002);
		$display("test reset_values done");

		@(posedge ref_clk);
		{cfg_load, cfg_port, cfg_ctrl, cfg_adv} <= {3'b111, 16'h0008, 16'h01A0};
		@(posedge ref_clk);
		cfg_load <= 1'b0;
		reg_read(OFS_CTRL + 8'h0C, rd);
		check_val(rd, 32'h0008);
		reg_read(OFS_ADV + 8'h0C, rd);
		check_val(rd, 32'h01A0);
		reg_write(OFS_MODE, 32'h1);
		repeat (2) @(posedge ref_clk);
		check_val(32'(gmii_isolate), 32'h8);
		reg_write(OFS_MODE, 32'h0);
		reg_write(OFS_CTRL + 8'h0C, 32'h0002);
		reg_write(OFS_CTRL + 8'h04, 32'h0002);
		repeat (2) @(posedge ref_clk);
		check_val(32'(gmii_isolate), 32'h0);
		reg_read(OFS_STAT, rd);
		check_val(rd & 32'h10, 32'h0);
		check_val(32'({gmii_rx_dv, gmii_rx_er}), 32'h0);
		$display("test config_and_unaligned done");

		repeat (8) begin
			@(posedge ref_clk);
			#1;
			for (int p = 0; p < 4; p++)
				check_val(32'({txcharisk[p], txdata[8*p +: 8]}), txcharisk[p] ?
					32'({1'b1, (p == 0) ? K28_1 : K28_5}) : 32'({1'b0, D5_6}));
		end
		$display("test idle_stream done");

		@(posedge ref_clk);
		link_up <= 1'b1;
		repeat (300) @(posedge ref_clk);
		reg_read(OFS_STAT, rd);
		check_val(rd, 32'h5F);
		$display("test alignment done");

		@(posedge ref_clk);
		clk_en <= 1'b0;
		#1;
		tx_hold = txdata;
		repeat (3) @(posedge ref_clk);
		#1;
		check_val(txdata, tx_hold);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		$display("test clock_enable done");

		fork
			send_frame(0);
			recv_frame(0);
			begin
				@(posedge ref_clk iff gmii_tx_en[0]);
				lat = 1; // byte already stood one period before this edge
				do begin
					@(posedge ref_clk);
					#1;
					lat++;
				end while (!(txdata[7:0] === K_SOP && txcharisk[0] === 1'b1) && lat < 12);
				check_val(32'(lat), 32'd5);
			end
		join
		for (int p = 1; p < 4; p++) begin
			fork
				send_frame(p);
				recv_frame(p);
			join
		end
		$display("test frames done");

		@(posedge ref_clk);
		disp_bad <= 4'h4;
		repeat (40) @(posedge ref_clk);
		reg_read(OFS_STAT, rd);
		check_val(rd & 32'h4, 32'h4);
		reg_write(OFS_CTRL + 8'h08, 32'h0006);
		repeat (40) @(posedge ref_clk);
		reg_read(OFS_STAT, rd);
		check_val(rd & 32'h1F, 32'h1B);
		@(posedge ref_clk);
		disp_bad <= 4'h0;
		reg_write(OFS_CTRL + 8'h08, 32'h0002);
		repeat (80) @(posedge ref_clk);
		reg_read(OFS_STAT, rd);
		check_val(rd, 32'h5F);
		$display("test disparity done");
		stop_test();
	end
endmodule : quad_sgmii_pcs_lane_mux_tb
`default_nettype wire
